// File: logic/tptu_pkg.sv
/*
 Package for the three-phase PWM timing unit: register map, field positions,
 reset values and the shared carrier types.
 Assumes a 32-bit Avalon-MM slave with word-aligned registers.
*/
package tptu_pkg;
   // Register byte offsets
   localparam logic [5:0] TPTU_OFF_HALF_PERIOD = 6'h00;
   localparam logic [5:0] TPTU_OFF_DEAD_TIME = 6'h04;
   localparam logic [5:0] TPTU_OFF_MIN_PULSE = 6'h08;
   localparam logic [5:0] TPTU_OFF_SYNC_WIDTH = 6'h0c;
   localparam logic [5:0] TPTU_OFF_DUTY_A = 6'h10;
   localparam logic [5:0] TPTU_OFF_DUTY_B = 6'h14;
   localparam logic [5:0] TPTU_OFF_DUTY_C = 6'h18;
   localparam logic [5:0] TPTU_OFF_MODE_CTRL = 6'h1c;
   localparam logic [5:0] TPTU_OFF_STATUS = 6'h20;
   localparam logic [5:0] TPTU_OFF_STEER = 6'h24;
   // Field positions
   localparam int TPTU_MODE_DOUBLE_BIT = 6;
   localparam int TPTU_STAT_HALF_BIT = 3;
   localparam int TPTU_STAT_RUN_BIT = 0;
   // Widths and reset values
   localparam int TPTU_DT_W = 10;
   localparam int TPTU_SW_W = 8;
   localparam int TPTU_STEER_W = 9;
   localparam logic [7:0] TPTU_SYNC_WIDTH_RST = 8'h27;
   localparam logic [31:0] TPTU_UNMAPPED_DATA = 32'h0000_0000;

   // Timing settings moved together on each sync rising edge
   typedef struct packed {
      logic [15:0] half_period;
      logic [9:0] dead_time;
      logic [15:0] min_pulse;
      logic [7:0] sync_width;
      logic [15:0] duty_a;
      logic [15:0] duty_b;
      logic [15:0] duty_c;
      logic [8:0] steer;
   } tptu_set_t;

   // One complementary output pair
   typedef struct packed {
      logic high;
      logic low;
   } tptu_pair_t;

   // Main counter direction states
   typedef enum logic [1:0] {
      TPTU_IDLE,
      TPTU_UP,
      TPTU_DOWN
   } tptu_state_t;
endpackage

// File: logic/tptu_timing_unit.sv
/*
 Three-phase centre-based PWM timing unit with an Avalon-MM register slave.
 Assumes one clock (the instruction clock) and an asynchronous active-low
 reset that is released here through two flip-flops.
 Software writes shadow registers over the bus at any time.
 The working copies move only on a sync rising edge.
 A write between edges waits, unseen, for the next edge.
 The main counter runs up for one half period and then down.
 Up half: counter shows 0 to half_period - 1.
 Down half: counter shows half_period down to 1.
 Both halves therefore last half_period ticks.
 A full period lasts twice half_period ticks.
 Outputs use a position that runs 0 .. half_period - 1 in both halves.
 In the down half that position is the counter minus one.
 This keeps the high pulse centred on the midpoint.
 The high side is on for duty minus dead time per half.
 The low side is on for half_period minus duty minus dead time.
 The gap between the two sides is twice the dead time.
 Outputs are computed from next-state values and registered.
 So an output flop lines up with the counter flop it belongs to.
 A pulse shorter than the minimum count is dropped whole.
 Dropping avoids switching a power device for a sliver of time.
 Sync is a down-counter loaded with width plus one.
 The sync level feeds the converter and the interrupt line.
 Single mode: one sync per period, at the start.
 Double mode: an extra sync at the midpoint as well.
 The midpoint sync reloads all settings for the second half.
 The status half bit is clear in the first half, set in the second.
 Nothing runs until period and all three duties were written.
 The run bit in status is an extra hint for software.
 Limitation: in double mode a sync longer than a half period merges pulses.
 Limitation: a half period of zero gives a degenerate period.
 Trade-off: reads cost one wait state for registered data.
 Writes complete with no wait state at all.
*/
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
// Function
// - 16-bit counter, one tick per clock
// - Half-period register counts ticks per half
// - Half-period is 16 bits up to ffff
// - Dead time is twice dead-time count
// - Dead-time 10 bits, zero means none
// - Mode bit 6 selects double update
// - Reset clears the update-mode bit
// - Single mode: one sync per period
// - Sync rising edge latches timing settings
// - Sync edge also latches output steering
// - Double mode adds midpoint sync pulse
// - Midpoint sync edge latches all again
// - Status bit 3 marks second half
// - Sync stays high width plus one
// - Sync-width register resets to 0x27
// - Sync pulse goes to converter subsystem
// - Three 16-bit duty registers, one per phase
// - Duty is centred high-side on-time per half; here the high side is on for duty minus dead time
// - Idle until period and duties written
// - Drop pulses shorter than minimum count
// - Each sync pulse raises an interrupt
module tptu_timing_unit
   import tptu_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output tptu_pair_t phase_a,
   output tptu_pair_t phase_b,
   output tptu_pair_t phase_c,
   output logic [8:0] output_steer_q,
   output logic period_sync_pulse,
   output logic sync_irq
);

   // Reset release synchroniser
   logic rst_meta_q;
   logic rst_sync_q;
   logic rst_n;

   // Software registers (shadow copies)
   tptu_set_t shadow_q, shadow_d;
   logic mode_double_q, mode_double_d;
   logic [3:0] written_q, written_d; // Period, duty a, b, c seen
   // Working copies and generator state
   tptu_set_t work_q, work_d;
   tptu_state_t state_q, state_d;
   logic [15:0] count_q, count_d;
   logic [8:0] sync_cnt_q, sync_cnt_d; // Ticks left of the sync pulse
   logic second_half_q, second_half_d;
   logic [2:0] high_q, high_d;
   logic [2:0] low_q, low_d;
   logic rd_ack_q, rd_ack_d;
   logic [31:0] rdata_q, rdata_d;

   // Reset release: asynchronous assert, synchronous release
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // Byte-lane merge for a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Pulse gating: on-time below the minimum is dropped entirely
   function automatic logic keep(input logic [16:0] on_t, input logic [15:0] min_t);
      return on_t >= {1'b0, min_t};
   endfunction

   // Writes take one cycle, reads wait one cycle for registered data
   always_comb begin
      avs_waitrequest = avs_read && !rd_ack_q;
   end
   assign avs_readdata = rdata_q;

   // Register file: next values of shadow registers and read data
   always_comb begin
      logic [31:0] w;
      w = 32'h0000_0000;
      shadow_d = shadow_q;
      mode_double_d = mode_double_q;
      written_d = written_q;
      rd_ack_d = avs_read && !rd_ack_q;
      rdata_d = rdata_q;
      if (avs_write) begin
         unique case (avs_address)
            TPTU_OFF_HALF_PERIOD: begin
               w = merge({16'h0000, shadow_q.half_period}, avs_writedata, avs_byteenable);
               shadow_d.half_period = w[15:0];
               written_d[0] = 1'b1;
            end
            TPTU_OFF_DEAD_TIME: begin
               w = merge({22'h000000, shadow_q.dead_time}, avs_writedata, avs_byteenable);
               shadow_d.dead_time = w[9:0];
            end
            TPTU_OFF_MIN_PULSE: begin
               w = merge({16'h0000, shadow_q.min_pulse}, avs_writedata, avs_byteenable);
               shadow_d.min_pulse = w[15:0];
            end
            TPTU_OFF_SYNC_WIDTH: begin
               w = merge({24'h000000, shadow_q.sync_width}, avs_writedata, avs_byteenable);
               shadow_d.sync_width = w[7:0];
            end
            TPTU_OFF_DUTY_A: begin
               w = merge({16'h0000, shadow_q.duty_a}, avs_writedata, avs_byteenable);
               shadow_d.duty_a = w[15:0];
               written_d[1] = 1'b1;
            end
            TPTU_OFF_DUTY_B: begin
               w = merge({16'h0000, shadow_q.duty_b}, avs_writedata, avs_byteenable);
               shadow_d.duty_b = w[15:0];
               written_d[2] = 1'b1;
            end
            TPTU_OFF_DUTY_C: begin
               w = merge({16'h0000, shadow_q.duty_c}, avs_writedata, avs_byteenable);
               shadow_d.duty_c = w[15:0];
               written_d[3] = 1'b1;
            end
            TPTU_OFF_MODE_CTRL: begin
               if (avs_byteenable[0]) begin
                  mode_double_d = avs_writedata[TPTU_MODE_DOUBLE_BIT];
               end
            end
            TPTU_OFF_STEER: begin
               w = merge({23'h000000, shadow_q.steer}, avs_writedata, avs_byteenable);
               shadow_d.steer = w[8:0];
            end
            default: begin
               // Status and unmapped offsets ignore writes
            end
         endcase
      end
      if (avs_read && !rd_ack_q) begin
         unique case (avs_address)
            TPTU_OFF_HALF_PERIOD: rdata_d = {16'h0000, shadow_q.half_period};
            TPTU_OFF_DEAD_TIME: rdata_d = {22'h000000, shadow_q.dead_time};
            TPTU_OFF_MIN_PULSE: rdata_d = {16'h0000, shadow_q.min_pulse};
            TPTU_OFF_SYNC_WIDTH: rdata_d = {24'h000000, shadow_q.sync_width};
            TPTU_OFF_DUTY_A: rdata_d = {16'h0000, shadow_q.duty_a};
            TPTU_OFF_DUTY_B: rdata_d = {16'h0000, shadow_q.duty_b};
            TPTU_OFF_DUTY_C: rdata_d = {16'h0000, shadow_q.duty_c};
            TPTU_OFF_MODE_CTRL: begin
               rdata_d = 32'h0000_0000;
               rdata_d[TPTU_MODE_DOUBLE_BIT] = mode_double_q;
            end
            TPTU_OFF_STATUS: begin
               rdata_d = 32'h0000_0000;
               rdata_d[TPTU_STAT_HALF_BIT] = second_half_q;
               rdata_d[TPTU_STAT_RUN_BIT] = (state_q != TPTU_IDLE);
            end
            TPTU_OFF_STEER: rdata_d = {23'h000000, shadow_q.steer};
            default: rdata_d = TPTU_UNMAPPED_DATA;
         endcase
      end
   end

   // Register file storage; reset starts in single update mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_q <= '0;
         shadow_q.sync_width <= TPTU_SYNC_WIDTH_RST;
         mode_double_q <= 1'b0;
         written_q <= 4'h0;
         rd_ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         shadow_q <= shadow_d;
         mode_double_q <= mode_double_d;
         written_q <= written_d;
         rd_ack_q <= rd_ack_d;
         rdata_q <= rdata_d;
      end
   end

   // Generator: counter, sync pulse, latching and output pairs
   always_comb begin
      logic sync_rise;
      logic [16:0] hi_on;
      logic [16:0] lo_on;
      logic [16:0] edge_hi;
      logic [16:0] edge_lo;
      logic [15:0] duty;
      logic [16:0] pos;
      sync_rise = 1'b0;
      pos = 17'h00000;
      hi_on = 17'h00000;
      lo_on = 17'h00000;
      edge_hi = 17'h00000;
      edge_lo = 17'h00000;
      duty = 16'h0000;
      state_d = state_q;
      count_d = count_q;
      work_d = work_q;
      second_half_d = second_half_q;
      sync_cnt_d = (sync_cnt_q != 9'h000) ? sync_cnt_q - 9'h001 : 9'h000;
      unique case (state_q)
         TPTU_IDLE: begin
            // Held idle until period and all duties have been written
            if (written_q == 4'hf) begin
               sync_rise = 1'b1;
               state_d = TPTU_UP;
               count_d = 16'h0000;
               second_half_d = 1'b0;
            end
         end
         TPTU_UP: begin
            // Count up through the first half period
            // Last up tick is half_period - 1, so the half lasts half_period ticks
            if ({1'b0, count_q} + 17'h00001 >= {1'b0, work_q.half_period}) begin
               state_d = TPTU_DOWN;
               count_d = work_q.half_period;
               second_half_d = 1'b1;
               sync_rise = mode_double_q;
            end else begin
               count_d = count_q + 16'h0001;
            end
         end
         TPTU_DOWN: begin
            // Count down through the second half; a count of one ends the period
            if (count_q <= 16'h0001) begin
               state_d = TPTU_UP;
               count_d = 16'h0000;
               second_half_d = 1'b0;
               sync_rise = 1'b1;
            end else begin
               count_d = count_q - 16'h0001;
            end
         end
         default: state_d = TPTU_IDLE;
      endcase
      if (sync_rise) begin
         work_d = shadow_q;
         sync_cnt_d = {1'b0, shadow_q.sync_width} + 9'h001;
         // A midpoint reload starts the second half from the new period
         if (state_d == TPTU_DOWN) begin
            count_d = shadow_q.half_period;
         end
      end
      // Position within the half: same range going up and going down
      // Built from next values so outputs line up with the counter flop
      pos = (state_d == TPTU_DOWN) ? {1'b0, count_d} - 17'h00001 : {1'b0, count_d};
      // High side is on while the counter is within duty minus dead time of the midpoint
      for (int p = 0; p < 3; p++) begin
         duty = (p == 0) ? work_d.duty_a : (p == 1) ? work_d.duty_b : work_d.duty_c;
         // Dead time moves each edge by the dead-time count inward
         hi_on = ({1'b0, duty} > {7'h00, work_d.dead_time}) ?
                 {1'b0, duty} - {7'h00, work_d.dead_time} : 17'h00000;
         lo_on = ({1'b0, work_d.half_period} > {1'b0, duty} + {7'h00, work_d.dead_time}) ?
                 {1'b0, work_d.half_period} - {1'b0, duty} - {7'h00, work_d.dead_time}
                 : 17'h00000;
         edge_hi = {1'b0, work_d.half_period} - hi_on;
         edge_lo = lo_on;
         // Zero dead time gives exact complements
         high_d[p] = (state_d != TPTU_IDLE) && keep(hi_on, work_d.min_pulse)
                     && hi_on != 17'h00000 && (pos >= edge_hi);
         low_d[p] = (state_d != TPTU_IDLE) && keep(lo_on, work_d.min_pulse)
                    && lo_on != 17'h00000 && (pos < edge_lo);
      end
   end

   // Generator storage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= TPTU_IDLE;
         count_q <= 16'h0000;
         work_q <= '0;
         work_q.sync_width <= TPTU_SYNC_WIDTH_RST;
         second_half_q <= 1'b0;
         sync_cnt_q <= 9'h000;
         high_q <= 3'b000;
         low_q <= 3'b000;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         work_q <= work_d;
         second_half_q <= second_half_d;
         sync_cnt_q <= sync_cnt_d;
         high_q <= high_d;
         low_q <= low_d;
      end
   end

   // Outputs come straight from flip-flops
   assign phase_a = '{high: high_q[0], low: low_q[0]};
   assign phase_b = '{high: high_q[1], low: low_q[1]};
   assign phase_c = '{high: high_q[2], low: low_q[2]};
   assign output_steer_q = work_q.steer;
   // Sync feeds the converter sequencer and the core interrupt
   assign period_sync_pulse = (sync_cnt_q != 9'h000);
   assign sync_irq = period_sync_pulse;

endmodule

// File: tb/tptu_timing_unit_monitor.sv
/* Port checker for the PWM timing unit.
 Assumes the design's clock and asynchronous active-low reset. */
module tptu_timing_unit_monitor
   import tptu_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire tptu_pair_t phase_a,
   input wire tptu_pair_t phase_b,
   input wire tptu_pair_t phase_c,
   input wire logic [8:0] output_steer_q,
   input wire logic period_sync_pulse,
   input wire logic sync_irq
);
   logic [15:0] hi_len_q, hi_len_d; // Ticks the sync has stayed high
   logic [7:0] width_q, width_d; // Shadow of the sync width setting
   logic [3:0] wr_q, wr_d; // Period and duties seen written
   logic acc_w; // Write accepted this cycle
   // Width is only written while idle, so the shadow equals the live copy
   always_comb begin
      acc_w = avs_write && !avs_waitrequest;
      hi_len_d = period_sync_pulse ? hi_len_q + 16'h0001 : 16'h0000;
      width_d = (acc_w && avs_address == TPTU_OFF_SYNC_WIDTH) ? avs_writedata[7:0] : width_q;
      wr_d = wr_q | {acc_w && avs_address == TPTU_OFF_DUTY_C,
         acc_w && avs_address == TPTU_OFF_DUTY_B,
         acc_w && avs_address == TPTU_OFF_DUTY_A,
         acc_w && avs_address == TPTU_OFF_HALF_PERIOD};
   end
   // Helper registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hi_len_q <= 16'h0000;
         width_q <= TPTU_SYNC_WIDTH_RST;
         wr_q <= 4'h0;
      end else begin
         hi_len_q <= hi_len_d;
         width_q <= width_d;
         wr_q <= wr_d;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_GAP_A: assert property (!(phase_a.high && phase_a.low))
      else $error("phase a pair overlaps");
   AST_GAP_B: assert property (!(phase_b.high && phase_b.low))
      else $error("phase b pair overlaps");
   AST_GAP_C: assert property (!(phase_c.high && phase_c.low))
      else $error("phase c pair overlaps");
   AST_SYNC_WIDTH: assert property ($fell(period_sync_pulse) |->
      hi_len_q == {8'h00, width_q} + 16'h0001) else $error("sync width wrong");
   AST_STEER: assert property ($changed(output_steer_q) |-> $rose(period_sync_pulse))
      else $error("steering moved off a sync edge");
   AST_IDLE: assert property (wr_q != 4'hf |->
      !period_sync_pulse && {phase_a, phase_b, phase_c} == 6'h00) else $error("active too early");
   AST_IRQ: assert property (sync_irq == period_sync_pulse)
      else $error("interrupt differs from sync");
   AST_WR_READY: assert property (avs_write |-> !avs_waitrequest)
      else $error("write stalled");
   AST_RD_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read answer late");
   cover property ($rose(period_sync_pulse));
   cover property ($fell(period_sync_pulse));
   cover property ($rose(avs_read));
endmodule
bind tptu_timing_unit tptu_timing_unit_monitor u_mon (.clk, .reset_n, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_waitrequest, .phase_a, .phase_b, .phase_c, .output_steer_q,
   .period_sync_pulse, .sync_irq);

// File: tb/tptu_drive_model.sv
/* Gate-driver and converter-side model: times each sync interval and the
 high-side on-time of each phase. Assumes registered design outputs. */
module tptu_drive_model
   import tptu_pkg::*;
(
   input wire logic clk,
   input wire tptu_pair_t phase_a,
   input wire tptu_pair_t phase_b,
   input wire tptu_pair_t phase_c,
   input wire logic period_sync_pulse,
   output int syncs,
   output int period,
   output int on_a,
   output int on_b,
   output int on_c
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt; // Ticks since the last sync rise
   int acc [3]; // High-side ticks per phase
   bit prev; // Sync level one tick ago
   // A sync rise opens an interval; results are published by NBA to avoid races
   always @(posedge clk) begin
      if (period_sync_pulse && !prev) begin
         syncs <= syncs + 1;
         period <= cnt;
         on_a <= acc[0];
         on_b <= acc[1];
         on_c <= acc[2];
         cnt = 0;
         acc = '{0, 0, 0};
      end
      cnt++;
      acc[0] += int'(phase_a.high);
      acc[1] += int'(phase_b.high);
      acc[2] += int'(phase_c.high);
      prev = period_sync_pulse;
   end
endmodule

// File: tb/three_phase_pwm_timing_unit_tb.sv
/* Self-checking bench for the PWM timing unit.
 Assumes a 200 MHz clock and a register bus master with one request at a time. */
module three_phase_pwm_timing_unit_tb
   import tptu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q, s1, s2;
   logic avs_waitrequest, period_sync_pulse, sync_irq;
   logic [8:0] output_steer_q;
   tptu_pair_t phase_a, phase_b, phase_c;
   logic [31:0] seed_q = 32'h0000_6cec; // Fixed random seed
   int fail_count = 0, num_checks = 0, syncs, period, on_a, on_b, on_c;
   int hp = 40, dt = 2, mp = 0; // Model copies of the settings
   int duty [3] = '{10, 20, 30};
   always #2.5 clk = ~clk;
   tptu_timing_unit dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .phase_a, .phase_b, .phase_c,
      .output_steer_q, .period_sync_pulse, .sync_irq);
   tptu_drive_model u_drv (.clk, .phase_a, .phase_b, .phase_c, .period_sync_pulse, .syncs,
      .period, .on_a, .on_b, .on_c);
   function automatic logic [31:0] xs();
      seed_q ^= seed_q << 13;
      seed_q ^= seed_q >> 17;
      seed_q ^= seed_q << 5;
      return seed_q;
   endfunction
   // High-side ticks per half period; short pulses are dropped
   function automatic int exp_on(int d);
      int t;
      t = d - dt;
      if (t < mp || t < 0) t = 0;
      return t;
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input int d);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 0);
      check(what, e, q);
   endtask
   task automatic sync_wait(input int n);
      int s;
      repeat (n) begin
         s = syncs;
         while (syncs == s) @(posedge clk);
      end
   endtask
   task automatic set_run();
      bus(1'b1, TPTU_OFF_MIN_PULSE, mp);
      bus(1'b1, TPTU_OFF_DEAD_TIME, dt);
      for (int i = 0; i < 3; i++) bus(1'b1, TPTU_OFF_DUTY_A + 6'(4 * i), duty[i]);
   endtask
   // Waits for settings to reach a full interval, then compares it
   task automatic run_chk(input int m);
      sync_wait(3);
      check("interval", m * hp, period);
      check("on a", m * exp_on(duty[0]), on_a);
      check("on b", m * exp_on(duty[1]), on_b);
      check("on c", m * exp_on(duty[2]), on_c);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog sized well above the expected run
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk("mode", TPTU_OFF_MODE_CTRL, 32'h0000_0000);
      rd_chk("width", TPTU_OFF_SYNC_WIDTH, 32'h0000_0027);
      rd_chk("unmapped", 6'h3c, TPTU_UNMAPPED_DATA);
      bus(1'b1, TPTU_OFF_HALF_PERIOD, 32'h0000_ffff);
      rd_chk("half max", TPTU_OFF_HALF_PERIOD, 32'h0000_ffff);
      bus(1'b1, TPTU_OFF_DEAD_TIME, 32'h0000_ffff);
      rd_chk("dead max", TPTU_OFF_DEAD_TIME, 32'h0000_03ff);
      bus(1'b1, TPTU_OFF_SYNC_WIDTH, 32'h0000_0003);
      bus(1'b1, TPTU_OFF_STEER, 32'h0000_01a5);
      bus(1'b1, TPTU_OFF_HALF_PERIOD, hp);
      check("idle", 32'h0000_0000, syncs);
      set_run();
      run_chk(2);
      check("steer", 32'h0000_01a5, 32'(output_steer_q));
      sync_wait(1);
      bus(1'b1, TPTU_OFF_STEER, 32'h0000_005a);
      check("steer held", 32'h0000_01a5, 32'(output_steer_q));
      sync_wait(1);
      check("steer new", 32'h0000_005a, 32'(output_steer_q));
      dt = 0;
      set_run();
      run_chk(2);
      dt = 2;
      mp = 9;
      set_run();
      run_chk(2);
      repeat (3) begin
         for (int i = 0; i < 3; i++) duty[i] = dt + int'(xs() % 32'(hp - 2 * dt + 1));
         set_run();
         run_chk(2);
      end
      bus(1'b1, TPTU_OFF_MODE_CTRL, 32'h0000_0040);
      run_chk(1);
      bus(1'b0, TPTU_OFF_STATUS, 0);
      s1 = q;
      sync_wait(1);
      bus(1'b0, TPTU_OFF_STATUS, 0);
      s2 = q;
      check("half flag", 32'(!s1[3]), 32'(s2[3]));
      duty[0] = 25;
      set_run();
      run_chk(1);
      give_verdict();
   end
endmodule
